// ===== esp_consts.svh
// Constants for the setpoint and telemetry port
`ifndef ESP_CONSTS_SVH
`define ESP_CONSTS_SVH

`define ESP_CLK_HZ          10000000
`define ESP_BUS_ADDR        7'h29
`define ESP_BUS_STOP_TH     8'h09
`define ESP_BUS_START_TH    8'h0a
`define ESP_BUS_FULL_TH     8'hf5
`define ESP_TIMEOUT_MS      500
`define ESP_PULSE_STOP_US   1080
`define ESP_PULSE_START_US  1090
`define ESP_PULSE_FULL_US   1900
`define ESP_PULSE_MAX_US    2500
`define ESP_CODE_IDLE       8'hfa
`define ESP_CODE_START      8'h28
`define ESP_CODE_RUN        8'hff
`define ESP_SAT8            8'hff
`define ESP_SP_MAX          8'hff
`define ESP_OT_LIMIT        9'h064
`define ESP_OC_LIMIT        10'h190
`define ESP_FW_VERSION      16'h0100
`define ESP_HW_ID           8'h5a
`define ESP_BUS_BYTES       4'h9

`endif

// ===== esp_pkg.sv
// Types shared by the setpoint and telemetry port
package esp_pkg;

  typedef enum logic [1:0] {
    MOT_IDLE  = 2'b00,
    MOT_START = 2'b01,
    MOT_RUN   = 2'b10
  } esp_motor_e;

  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b000,
    BUS_ADDR  = 3'b001,
    BUS_ACK   = 3'b010,
    BUS_WDATA = 3'b011,
    BUS_RDATA = 3'b100,
    BUS_RACK  = 3'b101
  } esp_bus_e;

  // Measurements supplied by the front ends
  typedef struct packed {
    logic [9:0]  current;     // 0.1 A per count
    logic [8:0]  temp;        // Signed degrees C
    logic [9:0]  voltage;     // 0.1 V per count
    logic [15:0] commPeriod;  // Microseconds
    logic        startDone;
    logic        faultIn;
  } esp_telem_s;

  typedef struct packed {
    logic       motorOn;
    logic       fullPower;
    logic [7:0] setpoint;
    logic       runFlag;
    logic       failFlag;
    logic       timeoutFlag;
    logic       overheatFlag;
    logic       overcurrentFlag;
  } esp_status_s;

endpackage

// ===== esp_setpoint_port.sv
// Setpoint receiver (bus or pulse) with telemetry read-back over the two-wire bus
`timescale 1ns/1ps
`include "esp_consts.svh"

module esp_setpoint_port
  import esp_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR  = `ESP_BUS_ADDR,
  parameter logic [7:0] HW_ID       = `ESP_HW_ID,      // Arbitrary value
  parameter logic [15:0] FW_VERSION = `ESP_FW_VERSION, // Arbitrary value
  parameter int TIMEOUT_CYC  = `ESP_TIMEOUT_MS * (`ESP_CLK_HZ / 1000),
  parameter int STOP_CYC     = `ESP_PULSE_STOP_US * (`ESP_CLK_HZ / 1000000),
  parameter int START_CYC    = `ESP_PULSE_START_US * (`ESP_CLK_HZ / 1000000),
  parameter int FULL_CYC     = `ESP_PULSE_FULL_US * (`ESP_CLK_HZ / 1000000),
  parameter int MAX_CYC      = `ESP_PULSE_MAX_US * (`ESP_CLK_HZ / 1000000),
  parameter int TO_W         = 23,
  parameter int PW_W         = 16
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        pulseMode,
  input  wire logic        pulseIn,
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire esp_telem_s  telem,
  output esp_status_s      status
);

  localparam int STEP_CYC = (FULL_CYC - STOP_CYC) / 255;

  // Pins are synchronous; two register stages per pin give edge detection
  logic sclQ, sclP, sdaQ, sdaP, pulseQ, pulseP;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclQ <= 1'b1; sclP <= 1'b1; sdaQ <= 1'b1; sdaP <= 1'b1;
      pulseQ <= 1'b0; pulseP <= 1'b0;
    end else begin
      sclQ <= scl; sclP <= sclQ; sdaQ <= sdaIn; sdaP <= sdaQ;
      pulseQ <= pulseIn; pulseP <= pulseQ;
    end
  end

  logic sclRise, sclFall, busStart, busStop;
  assign sclRise  = sclQ & ~sclP;
  assign sclFall  = ~sclQ & sclP;
  assign busStart = sclQ & sclP & sdaP & ~sdaQ;
  assign busStop  = sclQ & sclP & ~sdaP & sdaQ;

  // ---------------- Two-wire slave ----------------
  esp_bus_e   busSt_q;
  logic [3:0] bitCnt_q, byteIdx_q;
  logic [7:0] rxSh_q, txSh_q, txByte, spHigh_q;
  logic       rw_q, sda_q, busUpd_q;
  logic [15:0] spWord;
  esp_motor_e motSt_q;
  logic       toFlag_q, otFlag_q, ocFlag_q;

  assign spWord = {spHigh_q, 8'h00};

  // Byte served at read position byteIdx_q
  always_comb begin
    txByte = 8'h00;
    if (!pulseMode) begin
      unique case (byteIdx_q)
        4'h0: txByte = (telem.current > 10'({`ESP_SAT8})) ? `ESP_SAT8
                       : telem.current[7:0];
        4'h1: txByte = (motSt_q == MOT_IDLE)  ? `ESP_CODE_IDLE :
                       (motSt_q == MOT_START) ? `ESP_CODE_START : `ESP_CODE_RUN;
        4'h2: txByte = telem.temp[8] ? 8'h00 : telem.temp[7:0];
        4'h3: txByte = (telem.voltage > 10'({`ESP_SAT8})) ? `ESP_SAT8
                       : telem.voltage[7:0];
        4'h4: txByte = telem.commPeriod[15:8];
        4'h5: txByte = telem.commPeriod[7:0];
        4'h6: txByte = FW_VERSION[15:8];
        4'h7: txByte = FW_VERSION[7:0];
        4'h8: txByte = HW_ID;
        default: txByte = 8'h00;
      endcase
    end else begin
      unique case (byteIdx_q)
        4'h0: txByte = {motSt_q != MOT_IDLE, status.failFlag, toFlag_q, otFlag_q,
                        ocFlag_q, 1'b0, telem.current[9:8]};
        4'h1: txByte = telem.current[7:0];
        4'h2: txByte = telem.temp[8] ? 8'h00 : telem.temp[7:0];
        4'h3: txByte = {6'h00, telem.voltage[9:8]};
        4'h4: txByte = telem.voltage[7:0];
        4'h6: txByte = FW_VERSION[15:8];
        4'h7: txByte = FW_VERSION[7:0];
        4'h8: txByte = HW_ID;
        default: txByte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      busSt_q <= BUS_IDLE; bitCnt_q <= 4'h0; byteIdx_q <= 4'h0;
      rxSh_q <= 8'h00; txSh_q <= 8'h00; rw_q <= 1'b0; sda_q <= 1'b0;
      spHigh_q <= 8'h00; busUpd_q <= 1'b0;
    end else begin
      busUpd_q <= 1'b0;
      if (busStop) begin
        busSt_q <= BUS_IDLE;
        sda_q <= 1'b0;
      end else if (busStart) begin
        busSt_q <= BUS_ADDR; bitCnt_q <= 4'h0; byteIdx_q <= 4'h0;
        sda_q <= 1'b0;
      end else begin
        unique case (busSt_q)
          BUS_IDLE: ;
          BUS_ADDR, BUS_WDATA: begin
            if (sclRise) begin
              rxSh_q <= {rxSh_q[6:0], sdaQ};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == 4'h8) begin
              if (busSt_q == BUS_ADDR) begin
                // Write and read share one address, only the last bit differs
                if (rxSh_q[7:1] == SLAVE_ADDR) begin
                  rw_q <= rxSh_q[0];
                  sda_q <= 1'b1;
                  busSt_q <= BUS_ACK;
                end else begin
                  busSt_q <= BUS_IDLE;
                end
              end else begin
                if (byteIdx_q == 4'h0 && !pulseMode) begin
                  spHigh_q <= rxSh_q;
                  busUpd_q <= 1'b1;
                end
                // The low byte is acknowledged but not kept
                byteIdx_q <= byteIdx_q + 4'h1;
                sda_q <= 1'b1;
                busSt_q <= BUS_ACK;
              end
            end
          end
          BUS_ACK: begin
            if (sclFall) begin
              bitCnt_q <= 4'h0;
              if (rw_q) begin
                sda_q <= ~txByte[7];
                txSh_q <= {txByte[6:0], 1'b1};
                busSt_q <= BUS_RDATA;
              end else begin
                sda_q <= 1'b0;
                busSt_q <= BUS_WDATA;
              end
            end
          end
          BUS_RDATA: begin
            if (sclRise) begin
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall) begin
              if (bitCnt_q == 4'h8) begin
                sda_q <= 1'b0;
                byteIdx_q <= byteIdx_q + 4'h1;
                busSt_q <= BUS_RACK;
              end else begin
                sda_q <= ~txSh_q[7];
                txSh_q <= {txSh_q[6:0], 1'b1};
              end
            end
          end
          BUS_RACK: begin
            if (sclRise && sdaQ) begin
              busSt_q <= BUS_IDLE;
            end else if (sclFall) begin
              bitCnt_q <= 4'h0;
              sda_q <= ~txByte[7];
              txSh_q <= {txByte[6:0], 1'b1};
              busSt_q <= BUS_RDATA;
            end
          end
          default: busSt_q <= BUS_IDLE;
        endcase
      end
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe  = sda_q;

  // ---------------- Pulse width measurement ----------------
  logic [PW_W-1:0] hiCnt_q, stepCnt_q;
  logic [7:0]      pulseSp_q;
  logic            pulseUpd_q;
  logic [PW_W-1:0] pulseWidth_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      hiCnt_q <= '0; stepCnt_q <= '0; pulseSp_q <= 8'h00;
      pulseUpd_q <= 1'b0; pulseWidth_q <= '0;
    end else begin
      pulseUpd_q <= 1'b0;
      if (pulseQ && !pulseP) begin
        // The cycle that sees the rise already counts as high time
        hiCnt_q <= PW_W'(1); stepCnt_q <= '0; pulseSp_q <= 8'h00;
      end else if (pulseQ) begin
        if (hiCnt_q != PW_W'(MAX_CYC))
          hiCnt_q <= hiCnt_q + 1'b1;
        // Setpoint grows one count per step above the stop width
        if (hiCnt_q >= PW_W'(STOP_CYC)) begin
          if (stepCnt_q == PW_W'(STEP_CYC - 1)) begin
            stepCnt_q <= '0;
            if (pulseSp_q != `ESP_SP_MAX)
              pulseSp_q <= pulseSp_q + 8'h01;
          end else begin
            stepCnt_q <= stepCnt_q + 1'b1;
          end
        end
      end else if (pulseP && hiCnt_q != PW_W'(MAX_CYC) && pulseMode) begin
        // Over-long pulses count as missing, so they let the timeout run
        pulseUpd_q <= 1'b1;
        pulseWidth_q <= hiCnt_q;
      end
    end
  end

  // ---------------- Motor command ----------------
  logic upd, cmdStop, cmdStart, cmdFull;
  logic [TO_W-1:0] toCnt_q;
  logic fullPower_q;
  logic [7:0] setpoint_q;

  always_comb begin
    upd = pulseMode ? pulseUpd_q : busUpd_q;
    if (pulseMode) begin
      cmdStop  = pulseWidth_q < PW_W'(STOP_CYC);
      cmdStart = pulseWidth_q > PW_W'(START_CYC);
      cmdFull  = pulseWidth_q > PW_W'(FULL_CYC);
    end else begin
      cmdStop  = spWord[15:8] < `ESP_BUS_STOP_TH;
      cmdStart = spWord[15:8] > `ESP_BUS_START_TH;
      cmdFull  = spWord[15:8] > `ESP_BUS_FULL_TH;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      toCnt_q <= '0;
      toFlag_q <= 1'b0;
    end else if (upd) begin
      toCnt_q <= '0;
      toFlag_q <= 1'b0;
    end else if (toCnt_q == TO_W'(TIMEOUT_CYC - 1)) begin
      toFlag_q <= 1'b1;
    end else begin
      toCnt_q <= toCnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      motSt_q <= MOT_IDLE;
      fullPower_q <= 1'b0;
      setpoint_q <= 8'h00;
    end else if (upd) begin
      // A fresh update outranks a pending timeout, so the motor can restart at once
      setpoint_q <= cmdStop ? 8'h00 : (pulseMode ? pulseSp_q : spWord[15:8]);
      fullPower_q <= cmdFull && !cmdStop;
      if (cmdStop)
        motSt_q <= MOT_IDLE;
      else if (cmdStart && motSt_q == MOT_IDLE)
        motSt_q <= MOT_START;
    end else if (toFlag_q) begin
      motSt_q <= MOT_IDLE;
      fullPower_q <= 1'b0;
      setpoint_q <= 8'h00;
    end else if (motSt_q == MOT_START && telem.startDone) begin
      motSt_q <= MOT_RUN;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      otFlag_q <= 1'b0;
      ocFlag_q <= 1'b0;
    end else begin
      otFlag_q <= $signed(telem.temp) > $signed(`ESP_OT_LIMIT);
      ocFlag_q <= telem.current > `ESP_OC_LIMIT;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status.motorOn <= motSt_q != MOT_IDLE;
      status.fullPower <= fullPower_q;
      status.setpoint <= setpoint_q;
      status.runFlag <= motSt_q != MOT_IDLE;
      status.failFlag <= otFlag_q | ocFlag_q | telem.faultIn;
      status.timeoutFlag <= toFlag_q;
      status.overheatFlag <= otFlag_q;
      status.overcurrentFlag <= ocFlag_q;
    end
  end

  // ---------------- Assertions ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence sAddrDone;
    busSt_q == BUS_ADDR && bitCnt_q == 4'h8 && sclFall;
  endsequence

  a_addr_ack_match: assert property (sAddrDone ##0 (rxSh_q[7:1] == SLAVE_ADDR)
    |=> sda_q && busSt_q == BUS_ACK) else $error("Own address not acked");
  a_addr_ignore_other: assert property (sAddrDone ##0 (rxSh_q[7:1] != SLAVE_ADDR)
    |=> busSt_q == BUS_IDLE && !sda_q) else $error("Foreign address acked");
  a_bus_high_kept: assert property (busSt_q == BUS_WDATA && bitCnt_q == 4'h8 && sclFall
    && byteIdx_q == 4'h0 && !pulseMode |=> spHigh_q == $past(rxSh_q) && busUpd_q)
    else $error("High byte not stored");
  a_bus_low_ignored: assert property (busSt_q == BUS_WDATA && byteIdx_q != 4'h0
    |=> $stable(spHigh_q)) else $error("Low byte changed setpoint");
  a_bus_stop_cmd: assert property (!pulseMode && busUpd_q && !toFlag_q
    && spHigh_q < `ESP_BUS_STOP_TH |=> motSt_q == MOT_IDLE ##1 !status.motorOn)
    else $error("Low setpoint did not stop");
  a_bus_start_cmd: assert property (!pulseMode && busUpd_q && !toFlag_q
    && spHigh_q > `ESP_BUS_START_TH && motSt_q == MOT_IDLE |=> motSt_q == MOT_START)
    else $error("High setpoint did not start");
  a_full_power: assert property (upd && !toFlag_q && cmdFull |=> fullPower_q
    ##1 status.fullPower) else $error("Full power not applied");
  a_timeout_stop: assert property (toFlag_q && !upd |=> motSt_q == MOT_IDLE && !fullPower_q)
    else $error("Timeout did not stop motor");
  a_pulse_stop: assert property (pulseMode && pulseUpd_q && !toFlag_q
    && pulseWidth_q < PW_W'(STOP_CYC) |=> motSt_q == MOT_IDLE)
    else $error("Short pulse did not stop");
  a_idle_code: assert property (!pulseMode && byteIdx_q == 4'h1 && motSt_q == MOT_IDLE
    |-> txByte == `ESP_CODE_IDLE) else $error("Wrong idle code");
  a_run_flag: assert property (motSt_q != MOT_IDLE |=> status.runFlag)
    else $error("Run flag missing");

endmodule

// ===== esp_fcu_model.sv
// Flight controller model: two-wire bus master and pulse setpoint source
`timescale 1ns/1ps

module esp_fcu_model #(
  parameter int HALF = 20
) (
  input  wire logic mclk,
  input  wire logic sdaLine,
  output logic       sclOut,
  output logic       sdaLow,
  output logic       pulseOut,
  output logic       obsValid,
  output logic [7:0] obsVal
);
  // Bus idles released; the pull-up gives a high level on the wire
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
    pulseOut = 1'b0;
    obsValid = 1'b0;
    obsVal = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic emit(input logic [7:0] v);
    obsVal <= v;
    obsValid <= 1'b1;
    tick(1);
    obsValid <= 1'b0;
  endtask

  // Works as a repeated start too, since it begins with clock low
  task automatic start_cond;
    sdaLow <= 1'b0;
    tick(HALF / 2);
    sclOut <= 1'b1;
    tick(HALF);
    sdaLow <= 1'b1;
    tick(HALF);
    sclOut <= 1'b0;
    tick(HALF / 2);
  endtask

  // Data changes only mid-low, well after the slave's own release delay
  task automatic clock_bit(input logic drv, output logic seen);
    sdaLow <= ~drv;
    tick(HALF / 2);
    sclOut <= 1'b1;
    tick(HALF / 2);
    seen = sdaLine;
    tick(HALF / 2);
    sclOut <= 1'b0;
    tick(HALF / 2);
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
    clock_bit(1'b1, s);
    emit({7'h00, ~s});
  endtask

  // Last byte is answered with a release (no acknowledge) to end the read
  task automatic recv_byte(input logic last);
    logic [7:0] b;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      b[i] = s;
    end
    clock_bit(last, s);
    emit(b);
  endtask

  task automatic stop_cond;
    sdaLow <= 1'b1;
    tick(HALF / 2);
    sclOut <= 1'b1;
    tick(HALF);
    sdaLow <= 1'b0;
    tick(HALF);
  endtask

  task automatic pulse(input int width, input int gap);
    pulseOut <= 1'b1;
    tick(width);
    pulseOut <= 1'b0;
    tick(gap);
  endtask
endmodule

// ===== esc_setpoint_telemetry_port_test.sv
// Self-checking bench for the setpoint and telemetry port
`timescale 1ns/1ps
`include "esp_consts.svh"

module esc_setpoint_telemetry_port_test;
  import esp_pkg::*;
  localparam int TOC = 8000;
  localparam int PSTOP = 100;
  localparam int PFULL = 355;
  // Polls no faster than a fifth of the timeout: 10 Hz against 500 ms
  localparam int POLL = TOC / 5;
  localparam logic [15:0] FW = `ESP_FW_VERSION;
  typedef struct { string n; logic [7:0] v; logic [7:0] m; } esp_note_s;
  logic        mclk, rst, pulseMode, pulseIn, scl, sdaOut, sdaOe, fcuLow, sdaWire;
  logic        obsValid, probe;
  logic [7:0]  obsVal;
  esp_telem_s  telem;
  esp_status_s status;
  esp_note_s   noteQ[$];
  int          n_errors, checks, cyc, lastRd;

  esp_setpoint_port #(.TIMEOUT_CYC(TOC), .STOP_CYC(PSTOP), .START_CYC(110), .FULL_CYC(PFULL),
    .MAX_CYC(500)) dut_u (.mclk(mclk), .rst(rst), .pulseMode(pulseMode), .pulseIn(pulseIn),
    .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .telem(telem), .status(status));
  esp_fcu_model fcu_u (.mclk(mclk), .sdaLine(sdaWire), .sclOut(scl), .sdaLow(fcuLow),
    .pulseOut(pulseIn), .obsValid(obsValid), .obsVal(obsVal));
  // Open-drain data line with pull-up
  assign sdaWire = ~fcuLow & ~(sdaOe & ~sdaOut);

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic check_val(input string n, input logic [7:0] e, s, m);
    checks++;
    if ((s & m) !== (e & m)) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic note(input string n, input logic [7:0] v, input logic [7:0] m);
    noteQ.push_back('{n, v, m});
  endtask

  task automatic take(input logic [7:0] s);
    esp_note_s e;
    if (noteQ.size() == 0) begin
      n_errors++;
      $display("CHECK FAILED unexpected result expected none seen %h", s);
    end else begin
      e = noteQ.pop_front();
      check_val(e.n, e.v, s, e.m);
    end
  endtask

  always @(posedge mclk) begin
    if (obsValid === 1'b1) take(obsVal);
    if (probe === 1'b1) begin
      take({status.motorOn, status.fullPower, status.runFlag, status.failFlag,
            status.timeoutFlag, status.overheatFlag, status.overcurrentFlag, 1'b0});
      take(status.setpoint);
    end
  end

  function automatic logic hot();
    return $signed(telem.temp) > $signed(`ESP_OT_LIMIT);
  endfunction
  function automatic logic ovc();
    return telem.current > `ESP_OC_LIMIT;
  endfunction
  function automatic logic [7:0] sat(input logic [9:0] x);
    return (x > 10'h0ff) ? 8'hff : x[7:0];
  endfunction
  function automatic logic [7:0] tcl(input logic [8:0] t);
    return t[8] ? 8'h00 : t[7:0];
  endfunction
  // Pulse setpoint: full scale spread over the stop to full-power widths, saturating
  function automatic logic [7:0] psp(input int w);
    int v;
    v = (w - PSTOP) * 255 / (PFULL - PSTOP);
    return (v > 255) ? 8'hff : 8'(v);
  endfunction

  task automatic rnd_telem;
    telem.current <= 10'($urandom_range(400));
    telem.temp <= 9'($urandom_range(140)) - 9'h028;
    telem.voltage <= 10'($urandom);
    telem.commPeriod <= 16'($urandom);
    tick(2);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] hb, input logic ack);
    note("address ack", {7'h00, ack}, 8'hff);
    fcu_u.start_cond();
    fcu_u.send_byte({a, 1'b0});
    if (ack) begin
      note("high byte ack", 8'h01, 8'hff);
      fcu_u.send_byte(hb);
      note("low byte ack", 8'h01, 8'hff);
      fcu_u.send_byte(8'($urandom_range(255)));
    end
    fcu_u.stop_cond();
  endtask

  task automatic rd(input logic [7:0] e[$]);
    while (cyc - lastRd < POLL) tick(1);
    note("read address ack", 8'h01, 8'hff);
    foreach (e[i]) note("read byte", e[i], 8'hff);
    fcu_u.start_cond();
    fcu_u.send_byte({`ESP_BUS_ADDR, 1'b1});
    for (int i = 0; i < e.size(); i++) fcu_u.recv_byte(i == e.size() - 1);
    fcu_u.stop_cond();
    lastRd = cyc;
  endtask

  // Run flag follows the motor; failure is any of the fault sources
  task automatic chk(input logic on, full, to, input logic [7:0] sp, m);
    tick(12);
    note("status flags", {on, full, on, hot() | ovc() | telem.faultIn, to, hot(), ovc(), 1'b0},
         8'hfe);
    note("setpoint", sp, m);
    probe <= 1'b1;
    tick(1);
    probe <= 1'b0;
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_errors++;
      $display("CHECK FAILED run time expected end seen hang");
      complete_run();
    end
  end

  localparam logic [7:0] SP_TAB [6] = '{8'hff, 8'hf5, 8'h09, 8'h08, 8'h0a, 8'h0b};
  localparam bit ON_TAB [6] = '{1, 1, 1, 0, 0, 1};
  localparam bit FULL_TAB [6] = '{1, 0, 0, 0, 0, 0};

  initial begin
    logic [7:0] e[$];
    {rst, pulseMode, probe} = 3'b100;
    telem = '0;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    void'($urandom(54));
    tick(20);
    rst <= 1'b0;
    tick(3);
    rnd_telem();
    wr(7'h2a, 8'h00, 1'b0);
    chk(0, 0, 0, 8'h00, 8'hff);
    wr(`ESP_BUS_ADDR, 8'h64, 1'b1);
    chk(1, 0, 0, 8'h64, 8'hff);
    rd('{sat(telem.current), `ESP_CODE_START});
    $display("Test bus write and start done");
    telem.startDone <= 1'b1;
    // Refresh keeps the setpoint timeout away while the next poll is paced
    wr(`ESP_BUS_ADDR, 8'h64, 1'b1);
    rnd_telem();
    e = '{sat(telem.current), `ESP_CODE_RUN, tcl(telem.temp), sat(telem.voltage),
          telem.commPeriod[15:8], telem.commPeriod[7:0], FW[15:8], FW[7:0], `ESP_HW_ID, 8'h00};
    rd(e);
    $display("Test bus telemetry done");
    for (int i = 0; i < 6; i++) begin
      wr(`ESP_BUS_ADDR, SP_TAB[i], 1'b1);
      chk(ON_TAB[i], FULL_TAB[i], 0, (SP_TAB[i] < `ESP_BUS_STOP_TH) ? 8'h00 : SP_TAB[i],
          8'hff);
      if (i == 3) rd('{sat(telem.current), `ESP_CODE_IDLE});
    end
    $display("Test bus thresholds done");
    tick(TOC + 20);
    chk(0, 0, 1, 8'h00, 8'hff);
    wr(`ESP_BUS_ADDR, 8'h3c, 1'b1);
    chk(1, 0, 0, 8'h3c, 8'hff);
    $display("Test bus timeout done");
    pulseMode <= 1'b1;
    fcu_u.pulse(90, 300);
    chk(0, 0, 0, 8'h00, 8'hff);
    fcu_u.pulse(120, 300);
    chk(1, 0, 0, psp(120), 8'hff);
    fcu_u.pulse(400, 300);
    chk(1, 1, 0, psp(400), 8'hff);
    fcu_u.pulse(600, 300);
    chk(1, 1, 0, psp(400), 8'hff);
    tick(TOC + 20);
    chk(0, 0, 1, 8'h00, 8'hff);
    $display("Test pulse setpoint done");
    rnd_telem();
    e = '{{1'b0, hot() | ovc() | telem.faultIn, 1'b1, hot(), ovc(), 1'b0, telem.current[9:8]},
          telem.current[7:0], tcl(telem.temp), {6'h00, telem.voltage[9:8]}, telem.voltage[7:0],
          8'h00, FW[15:8], FW[7:0], `ESP_HW_ID};
    rd(e);
    telem.current <= 10'h3ff;
    telem.temp <= 9'h078;
    telem.faultIn <= 1'b1;
    chk(0, 0, 1, 8'h00, 8'hff);
    $display("Test pulse telemetry and faults done");
    tick(5);
    if (noteQ.size() != 0) begin
      n_errors++;
      $display("CHECK FAILED pending results expected 0 seen %0d", noteQ.size());
    end
    complete_run();
  end
endmodule
